// >>> serial_port_pkg.sv
// Constants shared by the asynchronous serial port and its buffer
package serial_port_pkg;

  localparam logic [1:0]  MODE_SYNC          = 2'h0;
  localparam logic [1:0]  MODE_ASYNC8_TIMER  = 2'h1;
  localparam logic [1:0]  MODE_ASYNC9_FIXED  = 2'h2;
  localparam logic [1:0]  MODE_ASYNC9_TIMER  = 2'h3;

  localparam logic [7:0]  TIMER1_MAX         = 8'hFF;
  localparam logic [15:0] TIMER2_MAX         = 16'hFFFF;
  localparam logic [15:0] TIMER2_RESET       = 16'h0000;

  // Timer 2 prescale terminal counts: clock/2 in baud mode, clock/12 otherwise
  localparam logic [3:0]  T2_PRE_BAUD_LAST   = 4'h1;
  localparam logic [3:0]  T2_PRE_NORMAL_LAST = 4'hB;

  // Fixed-rate 16x tick: clock/4 gives clock/64 baud, clock/2 gives clock/32
  localparam logic [1:0]  FIXED_PRE_LAST     = 2'h3;
  localparam logic [1:0]  FIXED_PRE_DBL_LAST = 2'h1;

  localparam logic [3:0]  SAMPLE_LAST        = 4'hF;
  localparam logic [3:0]  SAMPLE_FIRST_MID   = 4'h7;
  localparam logic [3:0]  SAMPLE_SECOND_MID  = 4'h8;
  localparam logic [3:0]  SAMPLE_VOTE        = 4'h9;

  // Bits after the start bit: 8 data + stop, or 8 data + ninth + stop
  localparam logic [3:0]  TX_BITS_SHORT      = 4'h9;
  localparam logic [3:0]  TX_BITS_LONG       = 4'hA;
  localparam logic [3:0]  RX_STOP_IDX_SHORT  = 4'h9;
  localparam logic [3:0]  RX_STOP_IDX_LONG   = 4'hA;

  localparam logic [1:0]  TI_DELAY_CYCLES    = 2'h2;

  localparam int          FIFO_DEPTH_DEFAULT = 16;
  localparam int          FIFO_WIDTH_DEFAULT = 9;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_RUN  = 1'b1
  } rx_state_e;

endpackage : serial_port_pkg

// >>> async_serial_port.sv
// Asynchronous serial port, modes 1 to 3, with transmit FIFO
//
// How it works
// - Mode 1 frame: start, 8 data LSB-first, stop
// - Timer overflows feed baud circuit, divided by 16
// - Doubler bit cancels halving of timer 1 overflows
// - Timer 2 selects pick transmitter and receiver baud
// - Timer 2 counts clock/2 in baud mode
// - Baud mode: no overflow flag, no reload trigger
// - Transmit starts at next divide-by-16 rollover
// - Mode 1 transmit-done two cycles after stop
// - Receive starts on falling edge when enabled
// - Start edge resets receive divide-by-16 counter
// - Each bit decided by three-sample majority
// - Unconfirmed start bit abandons the reception
// - Mode 1 stop checks, then load and flag
// - Failed stop checks discard the whole frame
// - After mid stop bit, receiver returns idle
// - Modes 2, 3: eleven-bit frame with ninth bit
// - Mode 2 baud is clock/64, or clock/32 doubled
// - Modes 2, 3: transmit-done as stop starts
// - Modes 2, 3: load byte, ninth bit, flag
// - Mode 3: mode 2 frame, timer baud rate
// - Multiprocessor bit drops frames with ninth zero
// - Two mode bits select modes 0 to 3
`timescale 1ns/1ps
`default_nettype none

module serial_tx_fifo
  import serial_port_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH_DEFAULT,
  parameter int DEPTH = FIFO_DEPTH_DEFAULT
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             not_full_reg;
  wire              push = in_valid && not_full_reg;
  wire              pop  = out_ready && (count_reg != '0);
  wire  [AW:0]      count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  assign in_ready  = not_full_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      not_full_reg <= 1'b1;
    end else begin
      wr_ptr_reg   <= wr_ptr_reg + AW'(push);
      rd_ptr_reg   <= rd_ptr_reg + AW'(pop);
      count_reg    <= count_next;
      not_full_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end

  a_fifo_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    count_reg <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth");

endmodule : serial_tx_fifo

module async_serial_port
  import serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       rxd_pin,
  output logic            txd_pin,
  input  wire logic       mode_select_high,
  input  wire logic       mode_select_low,
  input  wire logic       multiprocessor_bit,
  input  wire logic       receive_enable,
  input  wire logic       transmit_ninth_bit,
  input  wire logic       baud_doubler,
  input  wire logic       tx_timer2_select,
  input  wire logic       rx_timer2_select,
  input  wire logic       timer1_overflow,
  input  wire logic       timer2_run,
  input  wire logic [7:0] timer2_reload_high,
  input  wire logic [7:0] timer2_reload_low,
  input  wire logic       timer2_reload_trigger_pin,
  input  wire logic       timer2_trigger_enable,
  input  wire logic       timer2_flag_clear,
  output logic            timer2_overflow_flag,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_write,
  output logic            tx_ready,
  input  wire logic       clear_receive_done,
  input  wire logic       clear_transmit_done,
  output logic [7:0]      serial_buffer,
  output logic            received_ninth_bit,
  output logic            receive_done_flag,
  output logic            transmit_done_flag,
  output logic            serial_irq
);

  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction : majority3

  // Pin synchronisers; the first stage feeds only the second
  logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
  logic trig_meta_reg, trig_sync_reg, trig_prev_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {rxd_meta_reg, rxd_sync_reg, rxd_prev_reg}    <= 3'h7;
      {trig_meta_reg, trig_sync_reg, trig_prev_reg} <= 3'h7;
    end else begin
      {rxd_meta_reg, rxd_sync_reg, rxd_prev_reg}    <= {rxd_pin, rxd_meta_reg, rxd_sync_reg};
      {trig_meta_reg, trig_sync_reg, trig_prev_reg} <= {timer2_reload_trigger_pin, trig_meta_reg, trig_sync_reg};
    end
  end

  // Mode decode
  wire [1:0] mode       = {mode_select_high, mode_select_low};
  wire       mode_async = (mode != MODE_SYNC);
  wire       nine_bit   = (mode == MODE_ASYNC9_FIXED) || (mode == MODE_ASYNC9_TIMER);
  wire       fixed_rate = (mode == MODE_ASYNC9_FIXED);

  // Timer 2: auto-reload counter, forced to clock/2 while it makes baud rate
  logic [3:0]  t2_pre_reg;
  logic [15:0] t2_cnt_reg;
  wire         t2_baud      = tx_timer2_select || rx_timer2_select;
  wire  [3:0]  t2_pre_last  = t2_baud ? T2_PRE_BAUD_LAST : T2_PRE_NORMAL_LAST;
  wire         t2_pre_tick  = timer2_run && (t2_pre_reg >= t2_pre_last);
  wire         t2_wrap      = t2_pre_tick && (t2_cnt_reg == TIMER2_MAX);
  wire         trig_fall    = trig_prev_reg && !trig_sync_reg;
  wire         trig_reload  = trig_fall && timer2_trigger_enable && !t2_baud;
  wire  [15:0] t2_reload    = {timer2_reload_high, timer2_reload_low};
  logic        t2_flag_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      t2_pre_reg  <= 4'h0;
      t2_cnt_reg  <= TIMER2_RESET;
      t2_flag_reg <= 1'b0;
    end else begin
      t2_pre_reg  <= t2_pre_tick ? 4'h0 : (timer2_run ? t2_pre_reg + 4'h1 : t2_pre_reg);
      t2_cnt_reg  <= (t2_wrap || trig_reload) ? t2_reload : t2_cnt_reg + 16'(t2_pre_tick);
      t2_flag_reg <= (t2_wrap && !t2_baud) || (t2_flag_reg && !timer2_flag_clear);
    end
  end
  assign timer2_overflow_flag = t2_flag_reg;

  // Timer 1 overflows, halved unless doubled; fixed mode 2 prescaler
  logic       t1_half_reg;
  logic [1:0] fix_pre_reg;
  wire        t1_tick      = timer1_overflow && (baud_doubler || t1_half_reg);
  wire  [1:0] fix_pre_last = baud_doubler ? FIXED_PRE_DBL_LAST : FIXED_PRE_LAST;
  wire        fix_tick     = (fix_pre_reg >= fix_pre_last);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      t1_half_reg <= 1'b0;
      fix_pre_reg <= 2'h0;
    end else begin
      t1_half_reg <= t1_half_reg ^ timer1_overflow;
      fix_pre_reg <= fix_tick ? 2'h0 : fix_pre_reg + 2'h1;
    end
  end

  // Sixteen-times-bit-rate ticks for each direction
  wire tx_tick = mode_async && (fixed_rate ? fix_tick : (tx_timer2_select ? t2_wrap : t1_tick));
  wire rx_tick = mode_async && (fixed_rate ? fix_tick : (rx_timer2_select ? t2_wrap : t1_tick));

  // Transmit buffer: software writes queue here instead of overwriting
  logic [8:0] fifo_data;
  logic       fifo_valid;
  logic       tx_loaded_reg;
  wire        fifo_pop = fifo_valid && !tx_loaded_reg && mode_async;

  serial_tx_fifo #(
    .WIDTH (FIFO_WIDTH_DEFAULT),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_data   ({transmit_ninth_bit, tx_data}),
    .in_valid  (tx_write),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Transmitter
  logic [3:0] tx_div_reg;
  logic       tx_active_reg;
  logic [9:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic [1:0] ti_delay_reg;
  logic       txd_reg;
  wire        tx_roll      = tx_tick && (tx_div_reg == SAMPLE_LAST);
  wire        tx_begin     = tx_roll && tx_loaded_reg && !tx_active_reg;
  wire        tx_step      = tx_roll && tx_active_reg && (tx_left_reg != 4'h0);
  wire        tx_end       = tx_roll && tx_active_reg && (tx_left_reg == 4'h0);
  wire        tx_stop_out  = tx_step && (tx_left_reg == 4'h1) && nine_bit;
  wire        ti_mode1_set = (ti_delay_reg == 2'h1);
  wire  [9:0] tx_frame     = nine_bit ? {1'b1, fifo_data} : {2'h3, fifo_data[7:0]};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_div_reg    <= 4'h0;
      tx_loaded_reg <= 1'b0;
      tx_active_reg <= 1'b0;
      tx_shift_reg  <= 10'h3FF;
      tx_left_reg   <= 4'h0;
      txd_reg       <= 1'b1;
    end else begin
      tx_div_reg <= tx_div_reg + 4'(tx_tick);
      if (fifo_pop) begin
        tx_shift_reg  <= tx_frame;
        tx_loaded_reg <= 1'b1;
      end else if (tx_begin) begin
        txd_reg       <= 1'b0;
        tx_active_reg <= 1'b1;
        tx_left_reg   <= nine_bit ? TX_BITS_LONG : TX_BITS_SHORT;
      end else if (tx_step) begin
        txd_reg       <= tx_shift_reg[0];
        tx_shift_reg  <= {1'b1, tx_shift_reg[9:1]};
        tx_left_reg   <= tx_left_reg - 4'h1;
      end else if (tx_end) begin
        tx_active_reg <= 1'b0;
        tx_loaded_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ti_delay_reg <= 2'h0;
    end else if (tx_end && !nine_bit) begin
      ti_delay_reg <= TI_DELAY_CYCLES;
    end else if (ti_delay_reg != 2'h0) begin
      ti_delay_reg <= ti_delay_reg - 2'h1;
    end
  end
  assign txd_pin = txd_reg;

  // Receiver
  rx_state_e  rx_state_reg;
  logic [3:0] rx_div_reg;
  logic [3:0] rx_idx_reg;
  logic       samp_a_reg, samp_b_reg;
  logic [8:0] rx_shift_reg;
  wire        rx_fall     = rxd_prev_reg && !rxd_sync_reg;
  wire        rx_start    = (rx_state_reg == RX_IDLE) && rx_fall && receive_enable && mode_async;
  wire        rx_vote_evt = (rx_state_reg == RX_RUN) && rx_tick && (rx_div_reg == SAMPLE_VOTE);
  wire        rx_vote     = majority3(samp_a_reg, samp_b_reg, rxd_sync_reg);
  wire        rx_abort    = rx_vote_evt && (rx_idx_reg == 4'h0) && rx_vote;
  wire  [3:0] rx_stop_idx = nine_bit ? RX_STOP_IDX_LONG : RX_STOP_IDX_SHORT;
  wire        rx_at_stop  = rx_vote_evt && (rx_idx_reg == rx_stop_idx);
  wire  [7:0] rx_data_w   = nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
  wire        rx_bit9_w   = nine_bit ? rx_shift_reg[8] : rx_vote;
  wire        rx_accept   = rx_at_stop && !receive_done_flag
                            && (!multiprocessor_bit || rx_bit9_w);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_state_reg <= RX_IDLE;
      rx_div_reg   <= 4'h0;
      rx_idx_reg   <= 4'h0;
      samp_a_reg   <= 1'b1;
      samp_b_reg   <= 1'b1;
      rx_shift_reg <= 9'h000;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state_reg <= RX_RUN;
            rx_div_reg   <= 4'h0;
            rx_idx_reg   <= 4'h0;
          end
        end
        RX_RUN: begin
          rx_div_reg <= rx_div_reg + 4'(rx_tick);
          if (rx_tick && rx_div_reg == SAMPLE_FIRST_MID) samp_a_reg <= rxd_sync_reg;
          if (rx_tick && rx_div_reg == SAMPLE_SECOND_MID) samp_b_reg <= rxd_sync_reg;
          if (rx_abort || rx_at_stop || !mode_async) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_vote_evt) begin
            if (rx_idx_reg != 4'h0) rx_shift_reg <= {rx_vote, rx_shift_reg[8:1]};
            rx_idx_reg <= rx_idx_reg + 4'h1;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Flags: a setting event wins over a same-cycle clear
  wire ri_next = rx_accept || (receive_done_flag && !clear_receive_done);
  wire ti_next = tx_stop_out || ti_mode1_set || (transmit_done_flag && !clear_transmit_done);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_buffer      <= 8'h00;
      received_ninth_bit <= 1'b0;
      receive_done_flag  <= 1'b0;
      transmit_done_flag <= 1'b0;
      serial_irq         <= 1'b0;
    end else begin
      if (rx_accept) begin
        serial_buffer      <= rx_data_w;
        received_ninth_bit <= rx_bit9_w;
      end
      receive_done_flag  <= ri_next;
      transmit_done_flag <= ti_next;
      serial_irq         <= ri_next || ti_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_mode1_stop_done;
    tx_end && !nine_bit;
  endsequence
  sequence s_stop_vote_fail;
    rx_at_stop && !rx_accept;
  endsequence

  a_start_at_roll: assert property ($fell(txd_pin) && !$past(tx_active_reg) |-> $past(tx_begin))
    else $error("Start bit not aligned to rollover");
  a_ti_mode1_delay: assert property (s_mode1_stop_done |-> ##3 transmit_done_flag)
    else $error("Mode 1 transmit-done not set two cycles after stop");
  a_ti_stop_place: assert property (tx_stop_out |=> transmit_done_flag && txd_pin)
    else $error("Transmit-done not set with stop bit");
  a_rx_enable_gate: assert property (rx_state_reg == RX_IDLE && !receive_enable |=> rx_state_reg == RX_IDLE)
    else $error("Reception started while disabled");
  a_rx_align_div: assert property (rx_start |=> rx_div_reg == 4'h0 && rx_state_reg == RX_RUN)
    else $error("Receive counter not reset on start edge");
  a_start_reject: assert property (rx_abort |=> rx_state_reg == RX_IDLE && !$rose(receive_done_flag))
    else $error("False start bit not abandoned");
  a_frame_discard: assert property (s_stop_vote_fail |=> $stable(serial_buffer) && $stable(received_ninth_bit))
    else $error("Discarded frame altered the buffer");
  a_frame_accept: assert property (rx_accept |=> receive_done_flag && serial_buffer == $past(rx_data_w)
    && rx_state_reg == RX_IDLE)
    else $error("Accepted frame not loaded");
  a_mp_filter: assert property (rx_at_stop && nine_bit && multiprocessor_bit && !rx_shift_reg[8]
    |-> !rx_accept)
    else $error("Data frame passed multiprocessor filter");
  a_irq_follow: assert property (serial_irq == (receive_done_flag || transmit_done_flag))
    else $error("Interrupt request disagrees with done flags");
  a_t2_noflag: assert property (t2_baud && t2_wrap && !t2_flag_reg |=> !t2_flag_reg)
    else $error("Timer 2 flag set in baud mode");

endmodule : async_serial_port

`default_nettype wire

// >>> remote_station.sv
// Remote serial station: sends frames on rxd_pin and decodes frames seen on txd_pin
`timescale 1ns/1ps
`default_nettype none

module remote_station (
  input  wire logic        mclk,
  input  wire logic        txd_pin,
  input  wire logic [15:0] bit_cycles,
  input  wire logic        long_frame,
  output logic             rxd_pin
);
  logic [10:0] got_q[$];
  logic [10:0] frame;
  int          i;

  // Line idles at the mark level between frames
  initial rxd_pin = 1'b1;

  task automatic drive(input logic v, input int c);
    @(posedge mclk);
    rxd_pin <= v;
    repeat (c - 1) @(posedge mclk);
  endtask : drive

  // Start low, data LSB first, ninth bit on long frames, then stop
  task automatic send_frame(input logic [7:0] data, input logic ninth, input logic stop, input logic glitch);
    logic [10:0] bits;
    int          n;
    bits = long_frame ? {stop, ninth, data, 1'b0} : {1'b0, stop, data, 1'b0};
    n = long_frame ? 11 : 10;
    // A short low pulse must not be taken as a start bit
    if (glitch) begin
      drive(1'b0, 4);
      drive(1'b1, 40);
    end
    for (int k = 0; k < n; k++) drive(bits[k], bit_cycles);
    drive(1'b1, bit_cycles);
  endtask : send_frame

  // Samples at mid bit; no wait after the stop sample so back-to-back frames are caught
  always begin
    @(negedge txd_pin);
    repeat (bit_cycles / 2) @(posedge mclk);
    frame = '0;
    frame[0] = txd_pin;
    for (i = 1; i < (long_frame ? 11 : 10); i++) begin
      repeat (bit_cycles) @(posedge mclk);
      frame[i] = txd_pin;
    end
    got_q.push_back(frame);
  end
endmodule : remote_station

`default_nettype wire

// >>> async_serial_port_modes_bench.sv
// Self-checking bench for the asynchronous serial port with a reference model
`timescale 1ns/1ps
`default_nettype none

module async_serial_port_modes_bench;
  import serial_port_pkg::*;
  logic mclk, sys_rst, rxd_pin, txd_pin, msh, msl, mp, ren, tb8, dbl, txs, rxs, t1_ovf, t2_run;
  logic [7:0] rl_hi, rl_lo, tx_data, serial_buffer;
  logic t2_trig, t2_trig_en, t2_clr, t2_flag, tx_write, tx_ready, clr_ri, clr_ti, rb8, ri, ti, irq;
  logic [15:0] bitc;
  logic [10:0] exp_q[$];
  logic [7:0] m_serial_buffer;
  logic m_rb8, m_ri, acc;
  int err_total, n_tests, m_cnt, w, k;
  logic [4:0] c1[6] = '{5'b10001, 5'b01000, 5'b11001, 5'b11010, 5'b11111, 5'b10001};
  logic [4:0] c2[3] = '{5'b11010, 5'b11011, 5'b11000};

  async_serial_port dut_u (.mclk(mclk), .sys_rst(sys_rst), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .mode_select_high(msh), .mode_select_low(msl), .multiprocessor_bit(mp), .receive_enable(ren),
    .transmit_ninth_bit(tb8), .baud_doubler(dbl), .tx_timer2_select(txs), .rx_timer2_select(rxs),
    .timer1_overflow(t1_ovf), .timer2_run(t2_run), .timer2_reload_high(rl_hi), .timer2_reload_low(rl_lo),
    .timer2_reload_trigger_pin(t2_trig), .timer2_trigger_enable(t2_trig_en), .timer2_flag_clear(t2_clr),
    .timer2_overflow_flag(t2_flag), .tx_data(tx_data), .tx_write(tx_write), .tx_ready(tx_ready),
    .clear_receive_done(clr_ri), .clear_transmit_done(clr_ti), .serial_buffer(serial_buffer),
    .received_ninth_bit(rb8), .receive_done_flag(ri), .transmit_done_flag(ti), .serial_irq(irq));
  remote_station station_u (.mclk(mclk), .txd_pin(txd_pin), .bit_cycles(bitc), .long_frame(msh),
    .rxd_pin(rxd_pin));

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic cfg(input logic [1:0] mode, input logic d, input logic s, input int b);
    @(posedge mclk);
    {msh, msl} <= mode;
    dbl <= d;
    txs <= s;
    rxs <= s;
    bitc <= 16'(b);
  endtask : cfg

  // Software clears both done flags itself
  task automatic clr_flags(input logic r, input logic t);
    @(posedge mclk);
    clr_ri <= r;
    clr_ti <= t;
    @(posedge mclk);
    clr_ri <= 1'b0;
    clr_ti <= 1'b0;
    if (r) m_ri = 1'b0;
  endtask : clr_flags

  task automatic write_tx(input logic [7:0] d, input logic n);
    @(posedge mclk);
    tx_data <= d;
    tb8 <= n;
    tx_write <= 1'b1;
    #1;
    chk(tx_ready, m_cnt < 16, "tx_ready");
    if (m_cnt < 16) begin
      m_cnt++;
      exp_q.push_back(msh ? {1'b1, n, d, 1'b0} : {2'b01, d, 1'b0});
    end
    @(posedge mclk);
    tx_write <= 1'b0;
  endtask : write_tx

  task automatic tx_check;
    for (w = 0; w < 20000 && station_u.got_q.size() < exp_q.size(); w++) @(posedge mclk);
    while (exp_q.size() > 0) begin
      if (station_u.got_q.size() > 0) chk(station_u.got_q.pop_front(), exp_q[0], "frame");
      else chk(11'h7FF, exp_q[0], "missing frame");
      void'(exp_q.pop_front());
    end
    m_cnt = 0;
    // Let the last stop bit finish, or its late done flag would undo the clear below
    repeat (bitc + 16'h0008) @(posedge mclk);
    for (w = 0; w < 100 && ti !== 1'b1; w++) @(posedge mclk);
    #1;
    chk(ti, 1'b1, "transmit done");
    chk(irq, 1'b1, "irq on transmit");
    clr_flags(1'b0, 1'b1);
    #1;
    chk(ti, 1'b0, "transmit done clear");
    chk(irq, m_ri, "irq after clear");
  endtask : tx_check

  // Case bits: clear after, enable, glitch, multiprocessor, stop or ninth value
  task automatic rx_case(input logic [4:0] c);
    logic [7:0] d;
    logic       b9;
    d = 8'($urandom);
    @(posedge mclk);
    mp <= c[1];
    ren <= c[3];
    station_u.send_frame(d, c[0], msh ? 1'b1 : c[0], c[2]);
    b9 = c[0];
    acc = c[3] && !m_ri && (!c[1] || b9);
    if (acc) begin
      m_serial_buffer = d;
      m_rb8 = b9;
      m_ri = 1'b1;
    end
    chk(serial_buffer, m_serial_buffer, "rx data");
    chk(rb8, m_rb8, "rx ninth");
    chk(ri, m_ri, "rx done");
    chk(irq, m_ri, "irq on receive");
    if (c[4]) clr_flags(1'b1, 1'b0);
  endtask : rx_case

  initial begin
    mclk = 0; sys_rst = 1; {msh, msl} = 2'b00; mp = 0; ren = 0; tb8 = 0; dbl = 0; txs = 0; rxs = 0;
    t1_ovf = 0; t2_run = 0; rl_hi = 8'h00; rl_lo = 8'h00; t2_trig = 1; t2_trig_en = 0; t2_clr = 0;
    tx_data = 8'h00; tx_write = 0; clr_ri = 0; clr_ti = 0; bitc = 16'h0010;
    err_total = 0; n_tests = 0; m_cnt = 0; m_serial_buffer = 8'h00; m_rb8 = 0; m_ri = 0;
    void'($urandom(90325));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk({txd_pin, tx_ready, ri, ti, irq, serial_buffer}, 13'h1800, "reset state");
    // Mode 0 is inert: FIFO fills to refusal, then drains in mode 1
    for (k = 0; k < 17; k++) write_tx(8'($urandom), 1'b0);
    repeat (200) @(posedge mclk);
    chk(station_u.got_q.size(), 0, "mode 0 silent");
    t1_ovf <= 1'b1;
    cfg(2'b01, 1'b1, 1'b0, 16);
    tx_check();
    $display("Test 1 done: fifo and mode 1 transmit");
    cfg(2'b01, 1'b0, 1'b0, 32);
    write_tx(8'($urandom), 1'b0);
    tx_check();
    foreach (c1[j]) rx_case(c1[j]);
    $display("Test 2 done: mode 1 receive");
    t1_ovf <= 1'b0;
    for (k = 0; k < 2; k++) begin
      cfg(2'b10, k[0], 1'b0, k ? 32 : 64);
      write_tx(8'($urandom), 1'b0);
      write_tx(8'($urandom), 1'b1);
      tx_check();
      foreach (c2[j]) rx_case(c2[j]);
    end
    $display("Test 3 done: mode 2");
    // Reload timer 2 from the trigger pin, then check overflow flag in both modes
    @(posedge mclk);
    {rl_hi, rl_lo} <= 16'hFFFE;
    t2_run <= 1'b1;
    t2_trig_en <= 1'b1;
    t2_trig <= 1'b0;
    repeat (4) @(posedge mclk);
    t2_trig <= 1'b1;
    for (w = 0; w < 200 && t2_flag !== 1'b1; w++) @(posedge mclk);
    chk(t2_flag, 1'b1, "timer 2 flag normal");
    cfg(2'b11, 1'b0, 1'b1, 64);
    t2_clr <= 1'b1;
    @(posedge mclk);
    t2_clr <= 1'b0;
    repeat (200) @(posedge mclk);
    chk(t2_flag, 1'b0, "timer 2 flag baud");
    write_tx(8'($urandom), 1'b1);
    tx_check();
    foreach (c2[j]) rx_case(c2[j]);
    $display("Test 4 done: mode 3 on timer 2");
    report_and_stop();
  end

  // Whole run needs about 15000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : async_serial_port_modes_bench

`default_nettype wire
